// ==== design/esf_params.svh ====
// Constants for the event status flag block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef ESF_PARAMS_SVH
`define ESF_PARAMS_SVH

// Register offset and width
`define ESF_EVENT_STATUS_OFFSET 8'h00
`define ESF_REG_WIDTH           8

// Bit positions in the status byte
`define ESF_BIT_DATA_READY      7
`define ESF_BIT_OVERFLOW        6
`define ESF_BIT_BUFFER_EVENT    5
`define ESF_BIT_OUT_OF_BAND     4
`define ESF_BIT_IN_BAND         3
`define ESF_BIT_ORIENTATION     2
`define ESF_BIT_AUTO_SLEEP      1
`define ESF_BIT_BOOT_DONE       0

// Reset value: only boot-done set
`define ESF_EVENT_STATUS_RESET  8'h01

// Buffer mode disabled code
`define ESF_BUF_MODE_OFF        2'h0

// Interrupt pulse width in microseconds and clock rate in MHz
`define ESF_PULSE_WIDTH_US      5000
`define ESF_CLK_MHZ             250
`define ESF_PULSE_CYCLES        (`ESF_PULSE_WIDTH_US * `ESF_CLK_MHZ)

`endif

// ==== design/esf_pkg.sv ====
// Types shared by the event status flag block.
// Assumes nothing beyond a SystemVerilog compiler.
package esf_pkg;

  typedef logic [7:0] esf_byte_t;
  typedef logic [1:0] esf_buf_mode_t;

  // Interrupt pulse sequencer states
  typedef enum logic [0:0] {
    ESF_PULSE_IDLE,
    ESF_PULSE_ACTIVE
  } esf_pulse_state_t;

endpackage

// ==== design/esf_pulse_gen.sv ====
// Self-clearing pulse generator for the data-ready interrupt.
// Assumes trigger is a one-cycle pulse; standby ends the pulse at once.
`timescale 1ns/1ps
`include "esf_params.svh"

module esf_pulse_gen #(
  parameter int unsigned PULSE_CYCLES = `ESF_PULSE_CYCLES
) (
  input  wire logic clk_in,      // System clock
  input  wire logic rst_n_in,    // Synchronised reset, active low
  input  wire logic trigger_in,  // Start a new pulse
  input  wire logic standby_in,  // Device in standby
  output logic      pulse_out    // Pulse output
);
  import esf_pkg::*;

  esf_pulse_state_t state;
  esf_pulse_state_t next_state;
  logic [31:0]      count;
  logic [31:0]      next_count;
  wire logic        expired;

  // Terminal count of the pulse window
  assign expired   = (count >= PULSE_CYCLES - 32'h1);
  assign pulse_out = (state == ESF_PULSE_ACTIVE);

  // Next-state logic
  always_comb begin
    next_state = state;
    next_count = count;
    unique case (state)
      ESF_PULSE_IDLE: begin
        next_count = 32'h0;
        if (trigger_in && !standby_in) begin
          next_state = ESF_PULSE_ACTIVE;
        end
      end
      ESF_PULSE_ACTIVE: begin
        next_count = count + 32'h1;
        if (standby_in || expired) begin
          next_state = ESF_PULSE_IDLE;
          next_count = 32'h0;
        end
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ESF_PULSE_IDLE;
      count <= 32'h0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

endmodule

// ==== design/esf_event_status.sv ====
// Event status register of a three-axis motion sensor: flag logic and the
// status byte; the interrupt pulse timer is a submodule.
// Assumes a register interface that presents one-cycle read strobes and
// inputs synchronous to the clock; reset may be asserted at any time.
// Timing: strobes are sampled on the rising edge and show in the status
// byte from the next cycle on. A set and a clearing read in the same
// cycle leave the flag set, so a set landing during a read is not lost.
// The strap is registered, so a change of strap takes one cycle.
// Limits: the buffer, threshold, orientation and auto-sleep flags are
// levels owned by other functions and are copied here, one cycle late;
// the buffer flag is also masked to zero outside buffer mode.
`timescale 1ns/1ps
`include "esf_params.svh"

module esf_event_status #(
  parameter int unsigned PULSE_CYCLES = `ESF_PULSE_CYCLES
) (
  input  wire logic              clk_in,              // 250 MHz clock
  input  wire logic              reset_n_in,          // Async reset, active low
  input  wire logic              new_data_in,         // New result set latched, pulse
  input  wire logic              read_status_in,      // Status register read, pulse
  input  wire logic              read_axis_in,        // Axis output register read, pulse
  input  wire logic              read_vector_magnitude_regs_in,        // Vector magnitude register read, pulse
  input  wire esf_pkg::esf_buf_mode_t buf_mode_in,    // Buffer mode field
  input  wire logic              wake_pin_mode_strap_in, // Wake-pin mode strap
  input  wire logic              standby_in,          // Device in standby
  input  wire logic              buffer_event_in,     // Any buffer status event
  input  wire logic              out_of_band_in,      // Out-of-band event flag
  input  wire logic              in_band_in,          // In-band event flag
  input  wire logic              orientation_in,      // Orientation event flag
  input  wire logic              auto_sleep_in,       // Auto-sleep event flag
  input  wire logic              boot_clear_in,       // Clears boot-done, pulse
  output esf_pkg::esf_byte_t     event_status_out,    // Status byte
  output logic                   data_ready_int_out   // Data-ready interrupt
);
  import esf_pkg::*;

  // Reset synchroniser stages
  logic            rst_meta;        // First stage, read only by the second
  logic            rst_sync_n;      // Released copy of the reset

  // Registered state
  logic            strap_mode;      // Strap level, one cycle late
  logic            data_ready_flag; // Result set waiting for the host
  logic            overflow_flag;   // Result set overwritten unread
  logic            boot_done_flag;  // Boot sequence finished
  logic            set_unread;      // Latest set has had no axis read
  logic            pulse;           // Pulse-mode interrupt level

  // Decoded conditions and next values
  wire logic       buf_enabled;     // Output buffer in use
  wire logic       out_read;        // Axis or vector magnitude read
  wire logic       dr_set;          // Data-ready set event
  wire logic       dr_clear;        // Data-ready clear event
  wire logic       ovf_set;         // Overflow set event
  wire logic       ovf_clear;       // Overflow clear event
  wire logic       pulse_start;     // Starts an interrupt pulse
  wire logic       next_data_ready; // Data-ready after this edge
  wire logic       next_overflow;   // Overflow after this edge
  wire logic       next_set_unread; // Unread tracker after this edge
  wire logic       next_boot_done;  // Boot-done after this edge
  wire logic [4:1] pass_flags;      // Copied flags, status bit order
  wire esf_byte_t  next_status;     // Status byte after this edge

  // Reset release through two flops; assertion stays asynchronous.
  // Nothing but the second stage reads the first.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Buffer gating and output read decode
  assign buf_enabled = (buf_mode_in != `ESF_BUF_MODE_OFF);
  assign out_read    = read_axis_in | read_vector_magnitude_regs_in;

  // Data-ready events: a new set sets, any output read clears
  assign dr_set   = new_data_in;
  assign dr_clear = out_read;

  // Data-ready selection: buffer mode overrides everything,
  // then a set beats a clear in the same cycle
  assign next_data_ready = buf_enabled ? 1'b0 :
                           dr_set      ? 1'b1 :
                           dr_clear    ? 1'b0 :
                           data_ready_flag;

  // Unread tracker: only axis reads count as reading a set, so a
  // vector magnitude read alone leaves the set unread. Buffer mode
  // empties it, so leaving buffer mode cannot raise a stale overflow.
  assign next_set_unread = buf_enabled  ? 1'b0 :
                           new_data_in  ? 1'b1 :
                           read_axis_in ? 1'b0 :
                           set_unread;

  // Overflow events: a set landing on an unread set, and status reads.
  // An axis read in the same cycle as the new set comes too late.
  assign ovf_set   = new_data_in & set_unread;
  assign ovf_clear = read_status_in;

  // Overflow selection: buffer mode overrides, then set beats clear
  assign next_overflow = buf_enabled ? 1'b0 :
                         ovf_set     ? 1'b1 :
                         ovf_clear   ? 1'b0 :
                         overflow_flag;

  // Boot-done only ever falls after reset
  assign next_boot_done = boot_done_flag & ~boot_clear_in;

  // Flags owned by other functions, in status bit order
  assign pass_flags = {out_of_band_in, in_band_in, orientation_in, auto_sleep_in};

  // Status byte: owned flags from their next values, buffer flag gated by mode
  assign next_status[`ESF_BIT_DATA_READY]   = next_data_ready;
  assign next_status[`ESF_BIT_OVERFLOW]     = next_overflow;
  assign next_status[`ESF_BIT_BUFFER_EVENT] = buffer_event_in & buf_enabled;
  assign next_status[`ESF_BIT_BOOT_DONE]    = next_boot_done;

  // Copied flags, one bit each
  for (genvar b = `ESF_BIT_AUTO_SLEEP; b <= `ESF_BIT_OUT_OF_BAND; b++) begin : g_pass
    assign next_status[b] = pass_flags[b];
  end

  // Strap capture; the strap is a board tie,
  // so one cycle of lag is harmless
  always_ff @(posedge clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      strap_mode <= 1'b0;
    end else begin
      strap_mode <= wake_pin_mode_strap_in;
    end
  end

  // Data-ready flag; falls on output reads and in buffer mode,
  // rises on each new set outside buffer mode
  always_ff @(posedge clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      data_ready_flag <= 1'b0;
    end else begin
      data_ready_flag <= next_data_ready;
    end
  end

  // Overflow flag; falls on status reads and in buffer mode,
  // rises when a set lands on an unread one
  always_ff @(posedge clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      overflow_flag <= 1'b0;
    end else begin
      overflow_flag <= next_overflow;
    end
  end

  // Unread tracker register; empty after reset, so the
  // first set after reset never counts as an overflow
  always_ff @(posedge clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      set_unread <= 1'b0;
    end else begin
      set_unread <= next_set_unread;
    end
  end

  // Boot-done flag; set by reset only
  always_ff @(posedge clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      boot_done_flag <= 1'b1;
    end else begin
      boot_done_flag <= next_boot_done;
    end
  end

  // Status byte register, loaded from the next values so that the
  // byte never lags the owned flags it shows
  always_ff @(posedge clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      event_status_out <= `ESF_EVENT_STATUS_RESET;
    end else begin
      event_status_out <= next_status;
    end
  end

  // Pulse start: new sets outside buffer mode, in pulse mode only.
  // A set during a running pulse does not stretch it.
  assign pulse_start = new_data_in & ~buf_enabled & strap_mode;

  // Pulse mode interrupt; standby cuts a running pulse short
  // instead of letting it run to its full width
  esf_pulse_gen #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_pulse (
    .clk_in     (clk_in),
    .rst_n_in   (rst_sync_n),
    .trigger_in (pulse_start),
    .standby_in (standby_in),
    .pulse_out  (pulse)
  );

  // Interrupt select: the level follows the flag with the strap low,
  // the self-clearing pulse with it high
  assign data_ready_int_out = strap_mode ? pulse : data_ready_flag;

endmodule

// ==== dv/esf_host_model.sv ====
// Far-side model: turns bench requests into one-cycle strobes.
// Assumes requests change just after a rising edge.
`timescale 1ns/1ps
module esf_host_model (
  input  wire logic       clk_in,           // Clock
  input  wire logic [3:0] req_in,           // New, axis, vector_magnitude_regs, status
  output logic      [3:0] strobe_out = 4'h0 // Strobes to the block
);
  // Each request becomes a strobe one cycle later
  always @(posedge clk_in) strobe_out <= req_in;
endmodule

// ==== dv/esf_event_status_assertions.sv ====
// Port-level assertions for the event status flag block.
// Assumes it is bound to every instance of the block.
`timescale 1ns/1ps
module esf_event_status_assertions #(parameter int unsigned PULSE_CYCLES = 20) (
  input wire logic                   clk_in,
  input wire logic                   reset_n_in,
  input wire logic                   new_data_in,
  input wire logic                   read_status_in,
  input wire logic                   read_axis_in,
  input wire logic                   read_vector_magnitude_regs_in,
  input wire esf_pkg::esf_buf_mode_t buf_mode_in,
  input wire logic                   wake_pin_mode_strap_in,
  input wire logic                   standby_in,
  input wire logic                   orientation_in,
  input wire esf_pkg::esf_byte_t     event_status_out,
  input wire logic                   data_ready_int_out
);
  int unsigned hi;
  // Cycles the interrupt has stayed high
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in) hi <= 0;
    else hi <= data_ready_int_out ? hi + 1 : 0;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  buf_gate_a: assert property (buf_mode_in != 2'h0 |=> event_status_out[7:6] == 2'h0)
    else $error("flags not held low in buffer mode");
  ready_set_a: assert property (new_data_in && buf_mode_in == 2'h0 |=> event_status_out[7])
    else $error("data ready not set");
  ready_clr_a: assert property ((read_axis_in || read_vector_magnitude_regs_in) && !new_data_in |=> !event_status_out[7])
    else $error("data ready not cleared");
  ovf_clr_a: assert property (read_status_in && !new_data_in |=> !event_status_out[6])
    else $error("overflow not cleared");
  ovf_cause_a: assert property ($rose(event_status_out[6]) |-> $past(new_data_in))
    else $error("overflow without new data");
  int_follow_a: assert property ((!wake_pin_mode_strap_in)[*3] |-> data_ready_int_out == event_status_out[7])
    else $error("interrupt not following flag");
  standby_end_a: assert property (wake_pin_mode_strap_in && standby_in |=> !data_ready_int_out)
    else $error("pulse not ended by standby");
  pulse_width_a: assert property (wake_pin_mode_strap_in && data_ready_int_out |-> hi < PULSE_CYCLES)
    else $error("pulse too long");
  orient_pass_a: assert property (1'b1 |=> event_status_out[2] == $past(orientation_in))
    else $error("orientation flag not passed");
  buf_flag_gate_a: assert property (buf_mode_in == 2'h0 |=> !event_status_out[5])
    else $error("buffer flag set outside buffer mode");
endmodule
bind esf_event_status esf_event_status_assertions #(.PULSE_CYCLES(PULSE_CYCLES)) chk (.clk_in, .reset_n_in,
  .new_data_in, .read_status_in, .read_axis_in, .read_vector_magnitude_regs_in, .buf_mode_in, .wake_pin_mode_strap_in,
  .standby_in, .orientation_in, .event_status_out, .data_ready_int_out);

// ==== dv/esf_event_status_tb.sv ====
// Self-checking bench for the event status flag block.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
module esf_event_status_tb;
  import esf_pkg::*;
  localparam int PW = 20;
  logic          clk_in = 0, reset_n_in = 0, strap = 0, stby = 0, bclr = 0, irq;
  logic [3:0]    req = 0, rd;
  logic [4:0]    flg = 0;
  logic [31:0]   r;
  esf_buf_mode_t bm = 0;
  esf_byte_t     st;
  int            seed = 42, miscompares = 0, n_compared = 0, n;
  always #2 clk_in = ~clk_in;
  esf_host_model host (.clk_in(clk_in), .req_in(req), .strobe_out(rd));
  esf_event_status #(.PULSE_CYCLES(PW)) dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .new_data_in(rd[3]), .read_axis_in(rd[2]), .read_vector_magnitude_regs_in(rd[1]), .read_status_in(rd[0]),
    .buf_mode_in(bm), .wake_pin_mode_strap_in(strap), .standby_in(stby), .buffer_event_in(flg[4]),
    .out_of_band_in(flg[3]), .in_band_in(flg[2]), .orientation_in(flg[1]), .auto_sleep_in(flg[0]),
    .boot_clear_in(bclr), .event_status_out(st), .data_ready_int_out(irq));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Request strobes, then settle past the edge that samples them
  task automatic ev(input logic [3:0] p);
    @(posedge clk_in) req <= p;
    @(posedge clk_in) req <= 4'h0;
    @(posedge clk_in) #1;
  endtask
  task automatic summarize;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence: bit order of ev is new, axis, vector_magnitude_regs, status
  initial begin
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1;
    repeat (3) @(posedge clk_in);
    #1 chk(st, 8'h01);
    ev(4'h8); chk({st[7], irq}, 8'h3);
    ev(4'h4); chk({st[7], irq}, 8'h0);
    ev(4'h8); ev(4'h2); chk(st[7], 8'h0);
    ev(4'h8); chk(st[7:6], 8'h3);
    ev(4'h8); chk(st[7:6], 8'h3);
    ev(4'h1); chk(st[7:6], 8'h2);
    ev(4'h4); ev(4'h8); chk(st[7:6], 8'h2);
    ev(4'hC); chk(st[7], 8'h1);
    ev(4'h4); ev(4'h8); ev(4'h9); chk(st[7:6], 8'h3);
    $display("flag tests done");
    for (int m = 1; m < 4; m++) begin
      @(posedge clk_in) bm <= m[1:0];
      flg <= 5'h10;
      ev(4'h8); ev(4'h8); chk(st[7:5], 8'h1);
    end
    @(posedge clk_in) bm <= 2'h0;
    @(posedge clk_in) #1 chk(st[5], 8'h0);
    $display("buffer tests done");
    ev(4'h5);
    @(posedge clk_in) strap <= 1;
    repeat (3) @(posedge clk_in);
    ev(4'h8); n = 0;
    ev(4'h4); n = 3; chk({st[7], irq}, 8'h1);
    while (irq === 1'b1 && n < 99) begin
      @(posedge clk_in) #1 n++;
    end
    chk(8'(n), 8'(PW));
    ev(4'h8);
    @(posedge clk_in) stby <= 1;
    @(posedge clk_in) #1 chk(irq, 8'h0);
    @(posedge clk_in) stby <= 0;
    bclr <= 1;
    @(posedge clk_in) bclr <= 0;
    @(posedge clk_in) #1 chk(st[0], 8'h0);
    $display("pulse tests done");
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      @(posedge clk_in) flg <= r[4:0];
      @(posedge clk_in) #1 chk(st[5:1], {4'h0, r[3:0]});
    end
    $display("random tests done");
    summarize();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #20000;
    miscompares++;
    summarize();
  end
endmodule
